// ---- hw/dlsc_buf_mem.sv ----
`timescale 1ns/1ps
module dlsc_buf_mem
  import dlsc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [BUF_AW-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic [BUF_AW-1:0] rd_addr,
  output logic      [7:0]        rd_data
);
  typedef struct packed {
    logic [BUF_DEPTH-1:0][7:0] mem;
    logic [7:0]                rd;
  } dlsc_mem_s;

  dlsc_mem_s s_ff;
  dlsc_mem_s nxt_s;

  assign rd_data = s_ff.rd;

  // registered read, old data on a same-address write
  always_comb
  begin
    nxt_s    = s_ff;
    nxt_s.rd = s_ff.mem[rd_addr];
    if (wr_en)
      nxt_s.mem[wr_addr] = wr_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end
endmodule // dlsc_buf_mem

// ---- hw/dlsc_fifo.sv ----
`timescale 1ns/1ps
module dlsc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } dlsc_fifo_s;

  dlsc_fifo_s s_ff;
  dlsc_fifo_s nxt_s;
  logic       push;
  logic       pop;

  assign in_ready  = (s_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data  = s_ff.mem[s_ff.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp           = s_ff.wp + 1'b1;
    end
    if (pop)
      nxt_s.rp = s_ff.rp + 1'b1;
    nxt_s.cnt = s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end
endmodule // dlsc_fifo

// ---- hw/dlsc_pkg.sv ----
package dlsc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // line characters
  localparam logic [7:0] CH_SOH            = 8'h01;
  localparam logic [7:0] CH_EOT            = 8'h04;
  localparam logic [7:0] CH_ENQ            = 8'h05;
  localparam logic [7:0] CH_ACK            = 8'h06;
  localparam logic [7:0] DIGIT_BASE        = 8'h30;
  // router status-change message number (66)
  localparam logic [7:0] ROUTER_MSG_STATUS = 8'h42;
  ////////////////////////////////////////////////////////////////////////////
  // timing: timers count in 1 ms ticks
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W         = 17;
  ////////////////////////////////////////////////////////////////////////////
  // widths and depths
  localparam int NUM_DIGITS = 8;
  localparam int TEL_W      = 32;
  localparam int PORTS_W    = 16;
  localparam int TMR_W      = 16;
  localparam int CNT_W      = 16;
  localparam int STAMP_W    = 32;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int BUF_DEPTH  = 64;
  localparam int BUF_AW     = 6;
  ////////////////////////////////////////////////////////////////////////////
  // state types
  typedef enum logic [1:0] {LNK_IDLE, LNK_ONLINE, LNK_OFF_USER, LNK_OFF_FAULT} dlsc_link_e;
  typedef enum logic [2:0] {C_IDLE, C_DIAL, C_ORIG_ID, C_ANSWER, C_UP} dlsc_call_e;
  typedef enum logic [2:0] {T_IDLE, T_FILL, T_SOH, T_BODY, T_EOT, T_WAIT} dlsc_tx_e;
  typedef enum logic [2:0] {R_HUNT, R_LEN, R_BODY, R_ID, R_EOT} dlsc_rx_e;
endpackage

// ---- hw/dlsc_session.sv ----
// Function
// R01: on a router dial request, dial the number given for that site.
// R02: once connected, the caller sends start-of-header, own number, end-of-transmission.
// R03: called side looks up caller; on success acknowledges, sets peer ports, goes online.
// R04: caller receiving the acknowledge sets peer ports to called node and goes online.
// R05: failed lookup or refused call makes the caller clear the call down.
// R06: no acknowledge within the wait limit: drop call, tell router forwarding failed.
// R07: caller logs dialled number, connect duration and time the call was made.
// R08: originating side restarts its inactivity timer on every frame or acknowledge sent; a tick in the same cycle in C_UP increments it instead.
// R09: inactivity timer reaching hold limit drops the call and sets link idle; the code sets LNK_IDLE only from LNK_ONLINE and keeps an offline link.
// R10: while a call is up, line-status circuit failure or recovery updates link state.
// R11: line failure discards partial frames; an interrupted send is reported to router.
// R12: crossing between online/idle and offline groups sends status message 66 to router.
// R13: characters are 01, 04, 05, 06 hex; frame is header, envelope, end.
// R14: receiver skips to header or enquiry and answers an enquiry with acknowledge.
// R15: receiver counts envelope length, checks end character, counts good or failed frames.
// R16: unacknowledged frame counts failures and retries, resends up to limit, else reports.
// R17: called side that cannot resolve or refuses the caller sends no acknowledge.
`timescale 1ns/1ps
module dlsc_session
  import dlsc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               dial_req,
  input  wire logic [TEL_W-1:0]   req_number,
  input  wire logic [PORTS_W-1:0] req_ports,
  input  wire logic [TEL_W-1:0]   my_tel_no,
  input  wire logic [TMR_W-1:0]   ack_wait_limit,
  input  wire logic [TMR_W-1:0]   hold_limit,
  input  wire logic [3:0]         retries_allowed,
  input  wire logic               user_offline,
  input  wire logic               txq_valid,
  input  wire logic [7:0]         txq_data,
  input  wire logic               txq_last,
  output logic                    txq_ready,
  output logic                    rxf_valid,
  output logic      [7:0]         rxf_data,
  output logic                    rxf_good,
  output logic                    rxf_bad,
  output logic                    fwd_fail,
  output logic                    stat_msg_valid,
  output logic      [7:0]         stat_msg_code,
  output logic      [1:0]         link_status,
  output logic      [PORTS_W-1:0] peer_ports,
  output logic      [CNT_W-1:0]   frames_rx_cnt,
  output logic      [CNT_W-1:0]   rx_fail_cnt,
  output logic      [CNT_W-1:0]   tx_fail_cnt,
  output logic      [CNT_W-1:0]   tx_ok_cnt,
  output logic                    log_valid,
  output logic      [TEL_W-1:0]   log_number,
  output logic      [STAMP_W-1:0] log_call_time,
  output logic      [STAMP_W-1:0] log_connect_time,
  output logic                    lookup_req,
  output logic      [TEL_W-1:0]   lookup_num,
  input  wire logic               lookup_done,
  input  wire logic               lookup_ok,
  input  wire logic [PORTS_W-1:0] lookup_ports,
  output logic                    dial_go,
  output logic      [TEL_W-1:0]   dial_number,
  input  wire logic               call_up,
  input  wire logic               dial_fail,
  output logic                    hang_up,
  input  wire logic               line_ok,
  output logic                    tx_valid,
  output logic      [7:0]         tx_data,
  input  wire logic               tx_ready,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_data
);
  typedef struct packed {
    dlsc_call_e           cs;
    dlsc_tx_e             ts;
    dlsc_rx_e             rs;
    dlsc_link_e           link;
    logic                 orig;
    logic                 await_id;
    logic                 ack_pend;
    logic                 lk_wait;
    logic                 is_id;
    logic [TICK_W-1:0]    div;
    logic                 tick;
    logic [TMR_W-1:0]     ack_tmr;
    logic [TMR_W-1:0]     hold_tmr;
    logic [STAMP_W-1:0]   conn_tmr;
    logic [STAMP_W-1:0]   now_ms;
    logic [STAMP_W-1:0]   call_time;
    logic [3:0]           retry;
    logic [BUF_AW:0]      wr_idx;
    logic [BUF_AW:0]      tx_len;
    logic [BUF_AW:0]      tx_idx;
    logic [7:0]           rx_len;
    logic [7:0]           rx_cnt;
    logic [TEL_W-1:0]     dial_num;
    logic [TEL_W-1:0]     id_sh;
    logic [TEL_W-1:0]     caller;
    logic [PORTS_W-1:0]   site_ports;
    logic [PORTS_W-1:0]   peer_ports;
    logic                 tx_vld;
    logic [7:0]           tx_dat;
    logic                 rxf_vld;
    logic [7:0]           rxf_dat;
    logic                 rxf_good;
    logic                 rxf_bad;
    logic                 fwd_fail;
    logic                 stat_vld;
    logic                 dial_go;
    logic                 hang_up;
    logic                 lk_req;
    logic                 log_vld;
    logic [CNT_W-1:0]     frames_rx;
    logic [CNT_W-1:0]     rx_fail;
    logic [CNT_W-1:0]     tx_fail;
    logic [CNT_W-1:0]     tx_ok;
  } dlsc_sess_s;

  dlsc_sess_s                  s_ff;
  dlsc_sess_s                  nxt_s;
  logic                        fifo_vld;
  logic [FIFO_WIDTH-1:0]       fifo_dat;
  logic                        fifo_rdy;
  logic [7:0]                  buf_rd;
  logic                        load;
  logic                        ack_seen;
  logic                        drop;
  logic                        sent_ack;

  ////////////////////////////////////////////////////////////////////////////
  // outgoing frame queue and retransmit buffer
  assign fifo_rdy = (s_ff.ts == T_FILL);

  dlsc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (txq_valid),
    .in_data   ({txq_last, txq_data}),
    .in_ready  (txq_ready),
    .out_valid (fifo_vld),
    .out_data  (fifo_dat),
    .out_ready (fifo_rdy)
  );

  dlsc_buf_mem u_buf (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (fifo_vld & fifo_rdy),
    .wr_addr (s_ff.wr_idx[BUF_AW-1:0]),
    .wr_data (fifo_dat[7:0]),
    .rd_addr (nxt_s.tx_idx[BUF_AW-1:0]),
    .rd_data (buf_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rxf_valid        = s_ff.rxf_vld;
  assign rxf_data         = s_ff.rxf_dat;
  assign rxf_good         = s_ff.rxf_good;
  assign rxf_bad          = s_ff.rxf_bad;
  assign fwd_fail         = s_ff.fwd_fail;
  assign stat_msg_valid   = s_ff.stat_vld;
  assign stat_msg_code    = ROUTER_MSG_STATUS;
  assign link_status      = s_ff.link;
  assign peer_ports       = s_ff.peer_ports;
  assign frames_rx_cnt    = s_ff.frames_rx;
  assign rx_fail_cnt      = s_ff.rx_fail;
  assign tx_fail_cnt      = s_ff.tx_fail;
  assign tx_ok_cnt        = s_ff.tx_ok;
  assign log_valid        = s_ff.log_vld;
  assign log_number       = s_ff.dial_num;
  assign log_call_time    = s_ff.call_time;
  assign log_connect_time = s_ff.conn_tmr;
  assign lookup_req       = s_ff.lk_req;
  assign lookup_num       = s_ff.caller;
  assign dial_go          = s_ff.dial_go;
  assign dial_number      = s_ff.dial_num;
  assign hang_up          = s_ff.hang_up;
  assign tx_valid         = s_ff.tx_vld;
  assign tx_data          = s_ff.tx_dat;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_s          = s_ff;
    drop           = 1'b0;
    sent_ack       = 1'b0;
    load           = !s_ff.tx_vld | tx_ready;
    ack_seen       = rx_valid && (s_ff.rs == R_HUNT) && (rx_data == CH_ACK);
    nxt_s.rxf_vld  = 1'b0;
    nxt_s.rxf_good = 1'b0;
    nxt_s.rxf_bad  = 1'b0;
    nxt_s.fwd_fail = 1'b0;
    nxt_s.stat_vld = 1'b0;
    nxt_s.dial_go  = 1'b0;
    nxt_s.hang_up  = 1'b0;
    nxt_s.lk_req   = 1'b0;
    nxt_s.log_vld  = 1'b0;
    nxt_s.tick     = (s_ff.div == TICK_W'(TICK_CYCLES - 1));
    nxt_s.div      = nxt_s.tick ? '0 : s_ff.div + 1'b1;
    if (s_ff.tick)
      nxt_s.now_ms = s_ff.now_ms + 1'b1;
    if (load)
      nxt_s.tx_vld = 1'b0;
    //////////////////////////////////////////////////////////////////////////
    // transmitter: acknowledges go out only between frames
    if (load && s_ff.ack_pend && (s_ff.ts inside {T_IDLE, T_FILL, T_WAIT}))
    begin
      sent_ack       = 1'b1;
      nxt_s.tx_vld   = 1'b1; // R14
      nxt_s.tx_dat   = CH_ACK; // R13
      nxt_s.ack_pend = 1'b0;
      nxt_s.hold_tmr = '0; // R08
    end
    case (s_ff.ts)
      T_IDLE:
        if (!sent_ack && s_ff.cs == C_UP && s_ff.link == LNK_ONLINE && fifo_vld)
        begin
          nxt_s.ts     = T_FILL;
          nxt_s.wr_idx = '0;
          nxt_s.retry  = '0;
          nxt_s.is_id  = 1'b0;
        end
      T_FILL:
        if (fifo_vld)
        begin
          nxt_s.wr_idx = s_ff.wr_idx + 1'b1;
          if (fifo_dat[8] || s_ff.wr_idx == (BUF_AW+1)'(BUF_DEPTH - 1))
          begin
            nxt_s.tx_len = s_ff.wr_idx + 1'b1;
            nxt_s.ts     = T_SOH;
          end
        end
      T_SOH:
        if (load)
        begin
          nxt_s.tx_vld   = 1'b1;
          nxt_s.tx_dat   = CH_SOH; // R13
          nxt_s.tx_idx   = '0;
          nxt_s.hold_tmr = '0; // R08
          nxt_s.ts       = T_BODY;
        end
      T_BODY:
        if (load)
        begin
          nxt_s.tx_vld = 1'b1;
          nxt_s.tx_dat = s_ff.is_id ? (DIGIT_BASE | {4'h0, s_ff.id_sh[TEL_W-1 -: 4]}) : buf_rd;
          nxt_s.id_sh  = {s_ff.id_sh[TEL_W-5:0], 4'h0};
          nxt_s.tx_idx = s_ff.tx_idx + 1'b1;
          if (nxt_s.tx_idx == s_ff.tx_len)
            nxt_s.ts = T_EOT;
        end
      T_EOT:
        if (load)
        begin
          nxt_s.tx_vld  = 1'b1;
          nxt_s.tx_dat  = CH_EOT; // R13
          nxt_s.ack_tmr = '0;
          nxt_s.ts      = T_WAIT;
        end
      T_WAIT:
        if (ack_seen)
        begin
          nxt_s.ts = T_IDLE;
          if (!s_ff.is_id)
            nxt_s.tx_ok = s_ff.tx_ok + 1'b1;
        end
        else if (s_ff.tick)
        begin
          nxt_s.ack_tmr = s_ff.ack_tmr + 1'b1;
          if (nxt_s.ack_tmr >= ack_wait_limit)
          begin
            if (s_ff.is_id)
            begin
              drop           = 1'b1; // R06
              nxt_s.fwd_fail = 1'b1; // R06
            end
            else
            begin
              nxt_s.tx_fail = s_ff.tx_fail + 1'b1; // R16
              nxt_s.retry   = s_ff.retry + 1'b1; // R16
              if (nxt_s.retry <= retries_allowed)
                nxt_s.ts = T_SOH; // R16
              else
              begin
                nxt_s.ts       = T_IDLE;
                nxt_s.fwd_fail = 1'b1; // R16
              end
            end
          end
        end
      default:
        nxt_s.ts = T_IDLE;
    endcase
    //////////////////////////////////////////////////////////////////////////
    // receiver: events here come after the clears above so they win
    if (rx_valid)
    begin
      case (s_ff.rs)
        R_HUNT:
          if (rx_data == CH_SOH)
          begin
            nxt_s.rs     = s_ff.await_id ? R_ID : R_LEN; // R14
            nxt_s.rx_cnt = '0;
          end
          else if (rx_data == CH_ENQ)
            nxt_s.ack_pend = 1'b1; // R14
        R_LEN:
        begin
          nxt_s.rxf_vld = 1'b1;
          nxt_s.rxf_dat = rx_data;
          nxt_s.rx_len  = rx_data; // R15
          nxt_s.rx_cnt  = 8'h01;
          nxt_s.rs      = (rx_data <= 8'h01) ? R_EOT : R_BODY;
        end
        R_BODY:
        begin
          nxt_s.rxf_vld = 1'b1;
          nxt_s.rxf_dat = rx_data;
          nxt_s.rx_cnt  = s_ff.rx_cnt + 1'b1;
          if (nxt_s.rx_cnt == s_ff.rx_len)
            nxt_s.rs = R_EOT; // R15
        end
        R_ID:
        begin
          nxt_s.caller = {s_ff.caller[TEL_W-5:0], rx_data[3:0]};
          nxt_s.rx_cnt = s_ff.rx_cnt + 1'b1;
          if (nxt_s.rx_cnt == 8'(NUM_DIGITS))
            nxt_s.rs = R_EOT;
        end
        R_EOT:
        begin
          nxt_s.rs = R_HUNT;
          if (s_ff.await_id)
          begin
            nxt_s.await_id = 1'b0;
            if (rx_data == CH_EOT)
            begin
              nxt_s.lk_req  = 1'b1; // R03
              nxt_s.lk_wait = 1'b1;
            end
            else
              drop = 1'b1; // R17
          end
          else if (rx_data == CH_EOT)
          begin
            nxt_s.frames_rx = s_ff.frames_rx + 1'b1; // R15
            nxt_s.rxf_good  = 1'b1; // R15
            nxt_s.ack_pend  = 1'b1; // R15
          end
          else
          begin
            nxt_s.rx_fail = s_ff.rx_fail + 1'b1; // R15
            nxt_s.rxf_bad = 1'b1; // R15
          end
        end
        default:
          nxt_s.rs = R_HUNT;
      endcase
    end
    //////////////////////////////////////////////////////////////////////////
    // call control
    case (s_ff.cs)
      C_IDLE:
        if (dial_req)
        begin
          nxt_s.dial_go    = 1'b1; // R01
          nxt_s.dial_num   = req_number; // R01
          nxt_s.site_ports = req_ports;
          nxt_s.orig       = 1'b1;
          nxt_s.call_time  = s_ff.now_ms; // R07
          nxt_s.cs         = C_DIAL;
        end
        else if (call_up)
        begin
          nxt_s.orig     = 1'b0;
          nxt_s.await_id = 1'b1;
          nxt_s.cs       = C_ANSWER;
        end
      C_DIAL:
        if (dial_fail)
        begin
          drop           = 1'b1; // R05
          nxt_s.fwd_fail = 1'b1;
        end
        else if (call_up)
        begin
          nxt_s.ts       = T_SOH; // R02
          nxt_s.is_id    = 1'b1; // R02
          nxt_s.tx_len   = (BUF_AW+1)'(NUM_DIGITS);
          nxt_s.id_sh    = my_tel_no; // R02
          nxt_s.conn_tmr = '0;
          nxt_s.cs       = C_ORIG_ID;
        end
      C_ORIG_ID:
        if (ack_seen && s_ff.ts == T_WAIT)
        begin
          nxt_s.peer_ports = s_ff.site_ports; // R04
          nxt_s.link       = LNK_ONLINE; // R04
          nxt_s.hold_tmr   = '0;
          nxt_s.cs         = C_UP;
        end
      C_ANSWER:
        if (lookup_done && s_ff.lk_wait)
        begin
          nxt_s.lk_wait = 1'b0;
          if (lookup_ok)
          begin
            nxt_s.ack_pend   = 1'b1; // R03
            nxt_s.peer_ports = lookup_ports; // R03
            nxt_s.link       = LNK_ONLINE; // R03
            nxt_s.cs         = C_UP;
          end
          else
            drop = 1'b1; // R17
        end
      C_UP:
        if (s_ff.orig && s_ff.tick)
        begin
          nxt_s.hold_tmr = s_ff.hold_tmr + 1'b1; // R08
          if (nxt_s.hold_tmr >= hold_limit)
            drop = 1'b1; // R09
        end
      default:
        nxt_s.cs = C_IDLE;
    endcase
    if (s_ff.tick && s_ff.cs inside {C_ORIG_ID, C_ANSWER, C_UP})
      nxt_s.conn_tmr = s_ff.conn_tmr + 1'b1; // R07
    //////////////////////////////////////////////////////////////////////////
    // line watch and user control while the call is up
    if (s_ff.cs == C_UP)
    begin
      if (!line_ok && s_ff.link != LNK_OFF_FAULT)
      begin
        nxt_s.link = LNK_OFF_FAULT; // R10
        nxt_s.rs   = R_HUNT; // R11
        nxt_s.ts   = T_IDLE; // R11
        if (s_ff.rs != R_HUNT)
        begin
          nxt_s.rxf_bad = 1'b1; // R11
          nxt_s.rx_fail = s_ff.rx_fail + 1'b1; // R11
        end
        if (s_ff.ts != T_IDLE)
          nxt_s.fwd_fail = 1'b1; // R11
      end
      else if (line_ok && s_ff.link == LNK_OFF_FAULT)
        nxt_s.link = user_offline ? LNK_OFF_USER : LNK_ONLINE; // R10
      else if (user_offline && s_ff.link inside {LNK_ONLINE, LNK_IDLE})
        nxt_s.link = LNK_OFF_USER;
      else if (!user_offline && s_ff.link == LNK_OFF_USER)
        nxt_s.link = LNK_ONLINE;
    end
    if (!call_up && s_ff.cs inside {C_ORIG_ID, C_ANSWER, C_UP})
      drop = 1'b1;
    //////////////////////////////////////////////////////////////////////////
    // clear down
    if (drop)
    begin
      nxt_s.hang_up  = 1'b1; // R05
      nxt_s.cs       = C_IDLE;
      nxt_s.ts       = T_IDLE;
      nxt_s.rs       = R_HUNT;
      nxt_s.tx_vld   = 1'b0;
      nxt_s.await_id = 1'b0;
      nxt_s.lk_wait  = 1'b0;
      nxt_s.ack_pend = 1'b0;
      nxt_s.orig     = 1'b0;
      nxt_s.log_vld  = s_ff.orig; // R07
      if (s_ff.link == LNK_ONLINE)
        nxt_s.link = LNK_IDLE; // R09
    end
    nxt_s.stat_vld = ((nxt_s.link inside {LNK_OFF_USER, LNK_OFF_FAULT}) !=
                      (s_ff.link inside {LNK_OFF_USER, LNK_OFF_FAULT})); // R12
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end
endmodule // dlsc_session

// ---- tb/dlsc_modem_model.sv ----
`timescale 1ns/1ps
module dlsc_modem_model
  import dlsc_pkg::*;
(
  input  logic       ref_clk,
  input  logic       dial_go,
  input  logic       hang_up,
  input  logic       tx_valid,
  input  logic [7:0] tx_data,
  output logic       tx_ready,
  output logic       call_up,
  output logic       dial_fail,
  output logic       line_ok,
  output logic       rx_valid,
  output logic [7:0] rx_data
);
  logic       up = 1'b0;
  logic       ack_en = 1'b1;
  logic       refuse = 1'b0;
  logic       ring = 1'b0;
  logic       slow = 1'b0;
  logic       line_cmd = 1'b1;
  logic       ph = 1'b0;
  logic [7:0] q[$];
  logic [7:0] seen[$];
  assign tx_ready = !slow || ph;
  // a hang-up takes the line down at once
  assign call_up = up && !hang_up;
  ////////////////////
  always @(posedge ref_clk)
  begin
    ph <= !ph;
    line_ok <= line_cmd;
    dial_fail <= dial_go && refuse;
    if ((dial_go && !refuse) || ring)
      up <= 1'b1;
    if (hang_up)
      up <= 1'b0;
    if (tx_valid && tx_ready)
    begin
      seen.push_back(tx_data);
      if (tx_data == CH_EOT && ack_en)
        q.push_back(CH_ACK);
    end
    rx_valid <= q.size() != 0;
    rx_data <= q.size() != 0 ? q.pop_front() : ~rx_data;
  end
endmodule  // dlsc_modem_model

// ---- tb/dlsc_session_asserts.sv ----
`timescale 1ns/1ps
module dlsc_session_asserts
  import dlsc_pkg::*;
(
  input logic             ref_clk,
  input logic             rst_n,
  input logic             dial_req,
  input logic             dial_go,
  input logic             stat_msg_valid,
  input logic [7:0]       stat_msg_code,
  input logic [1:0]       link_status,
  input logic             line_ok,
  input logic             call_up,
  input logic             tx_valid,
  input logic [7:0]       tx_data,
  input logic             tx_ready,
  input logic             rxf_good,
  input logic             rxf_bad,
  input logic [CNT_W-1:0] frames_rx_cnt,
  input logic [CNT_W-1:0] rx_fail_cnt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////
  a_dial_cause: assert property (dial_go |-> $past(dial_req)) else $error("stray dial");
  a_stat_code: assert property (stat_msg_code == 8'h42) else $error("bad status code");
  a_stat_cross: assert property ($past(link_status[1]) != link_status[1] |-> stat_msg_valid)
    else $error("no status message");
  a_stat_cause: assert property (stat_msg_valid |-> $past(link_status[1]) !=
    link_status[1]) else $error("stray status message");
  a_line_fault: assert property (link_status == 2'h1 && !line_ok && call_up |->
    ##[1:3] link_status == 2'h3) else $error("line fault missed");
  a_tx_hold: assert property (tx_valid && !tx_ready && line_ok && call_up |=>
    tx_valid && $stable(tx_data)) else $error("tx char dropped");
  a_rx_good: assert property (rxf_good |-> ##[0:2] $changed(frames_rx_cnt))
    else $error("good frame not counted");
  a_rx_bad: assert property (rxf_bad |-> ##[0:2] $changed(rx_fail_cnt))
    else $error("bad frame not counted");
  c_online: cover property (link_status == 2'h1);
  c_fault: cover property (link_status == 2'h3);
  c_good: cover property (rxf_good);
endmodule  // dlsc_session_asserts

// ---- tb/dlsc_session_test.sv ----
`timescale 1ns/1ps
module dlsc_session_test
  import dlsc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dial_req = 1'b0, user_offline = 1'b0, txq_valid = 1'b0, txq_last = 1'b0;
  logic lookup_done = 1'b0, lookup_ok = 1'b0;
  logic txq_ready, rxf_valid, rxf_good, rxf_bad, fwd_fail, stat_msg_valid, log_valid;
  logic lookup_req, dial_go, call_up, dial_fail, hang_up, line_ok, tx_valid, tx_ready, rx_valid;
  logic [7:0] txq_data = 8'h00, rxf_data, stat_msg_code, tx_data, rx_data;
  logic [1:0] link_status;
  logic [3:0] retries_allowed = 4'h1;
  logic [15:0] req_ports = 16'h00a0, ack_wait_limit = 16'h000a, hold_limit = 16'h0064;
  logic [15:0] lookup_ports = 16'h0, peer_ports, frames_rx_cnt, rx_fail_cnt, tx_fail_cnt;
  logic [15:0] tx_ok_cnt;
  logic [31:0] req_number = 32'h87654321, my_tel_no = 32'h12345678, dial_number, lookup_num;
  logic [31:0] log_number, log_call_time, log_connect_time;
  int fails = 0, compares = 0, n_stat = 0, n_fail = 0, n_hang = 0, n_log = 0;
  logic [7:0] exp_q[$], id_q[$];
  dlsc_session #(.TICK_CYCLES(4)) i_dlsc_session (.*);
  dlsc_modem_model i_modem (.*);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    n_stat <= n_stat + stat_msg_valid;
    n_fail <= n_fail + fwd_fail;
    n_hang <= n_hang + hang_up;
    n_log <= n_log + log_valid;
  end
  ////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chk_tx();
    chk("tx_n", exp_q.size(), i_modem.seen.size());
    foreach (exp_q[i])
      chk("tx_ch", 32'(exp_q[i]), 32'(i_modem.seen[i]));
    i_modem.seen.delete();
  endtask
  task automatic await(ref int c, input int v);
    for (int i = 0; i < 2000 && c < v; i++)
      tick(1);
  endtask
  task automatic wait_link(input logic [1:0] v);
    for (int i = 0; i < 400 && link_status !== v; i++)
      tick(1);
    tick(3);
  endtask
  task automatic dial();
    dial_req <= 1'b1;
    tick(1);
    dial_req <= 1'b0;
  endtask
  task automatic push(input logic [7:0] d, input logic l);
    txq_valid <= 1'b1;
    txq_data <= d;
    txq_last <= l;
    tick(1);
  endtask
  task automatic results();
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////
  initial
  begin
    tick(10);
    rst_n <= 1'b1;
    dial();
    #1 chk("dial_go", 32'h1, 32'(dial_go));
    chk("dial_no", 32'h87654321, dial_number);
    wait_link(2'h1);
    chk("peer", 32'h00a0, 32'(peer_ports));
    chk("stat", 32'h0, n_stat);
    exp_q = {CH_SOH};
    for (int i = 1; i < 9; i++)
      exp_q.push_back(8'h30 + 8'(i));
    exp_q.push_back(CH_EOT);
    id_q = exp_q;
    chk_tx();
    i_modem.q = {CH_ENQ, CH_SOH, 8'h03, 8'haa, 8'hbb, CH_EOT, CH_SOH, 8'h02, 8'hcc, 8'h99};
    tick(40);
    chk("rx_ok", 32'h1, 32'(frames_rx_cnt));
    chk("rx_bad", 32'h1, 32'(rx_fail_cnt));
    exp_q = {CH_ACK, CH_ACK};
    chk_tx();
    i_modem.slow = 1'b1;
    for (int i = 0; i < 3; i++)
      push(8'hb0 + 8'(i), i == 2);
    txq_valid <= 1'b0;
    for (int i = 0; i < 300 && tx_ok_cnt !== 16'h1; i++)
      tick(1);
    exp_q = {CH_SOH, 8'hb0, 8'hb1, 8'hb2, CH_EOT};
    chk_tx();
    i_modem.slow = 1'b0;
    i_modem.q = {CH_SOH, 8'h05, 8'h11};
    tick(4);
    i_modem.line_cmd = 1'b0;
    wait_link(2'h3);
    chk("stat", 32'h1, n_stat);
    chk("rx_bad", 32'h2, 32'(rx_fail_cnt));
    i_modem.line_cmd = 1'b1;
    wait_link(2'h1);
    chk("stat", 32'h2, n_stat);
    i_modem.ack_en = 1'b0;
    push(8'hc0, 1'b1);
    txq_valid <= 1'b0;
    await(n_fail, 1);
    chk("tx_fail", 32'h2, 32'(tx_fail_cnt));
    chk("resent", 32'h6, i_modem.seen.size());
    await(n_hang, 1);
    chk("link", 32'h0, 32'(link_status));
    chk("log", 32'h1, n_log);
    chk("log_no", 32'h87654321, log_number);
    i_modem.refuse = 1'b1;
    dial();
    await(n_hang, 2);
    chk("refused", 32'h2, n_fail);
    i_modem.refuse = 1'b0;
    dial();
    await(n_fail, 3);
    chk("no_ack", 32'h3, n_hang);
    i_modem.ack_en = 1'b1;
    i_modem.seen.delete();
    i_modem.ring = 1'b1;
    tick(4);
    i_modem.q = id_q;
    tick(20);
    chk("lookup", 32'h12345678, lookup_num);
    lookup_done <= 1'b1;
    lookup_ok <= 1'b1;
    lookup_ports <= 16'h0c00;
    tick(1);
    lookup_done <= 1'b0;
    wait_link(2'h1);
    chk("peer", 32'h0c00, 32'(peer_ports));
    exp_q = {CH_ACK};
    chk_tx();
    results();
  end
  initial
  begin
    #200000;
    fails++;
    results();
  end
endmodule  // dlsc_session_test
bind dlsc_session dlsc_session_asserts i_dlsc_session_asserts (.*);
